// ### hw/acrp_port.v
// serial command interpreter and conversion readback of the converter
// assumes ref_clk far faster than sclk; pins are synchronised here
`timescale 1ns/1ns
`default_nettype none
`include "acrp_regs.vh"
module acrp_port (
    input wire ref_clk,
    input wire arst_n,
    input wire sclk,
    input wire cs_n,
    input wire din,
    input wire reset_pin_n,
    input wire timeout_evt,
    input wire converting,
    input wire conv_done,
    input wire [23:0] conv_data,
    input wire cal_done,
    input wire [23:0] cal_offset,
    output reg serial_out_with_ready,
    output wire serial_out_oe,
    output reg data_ready_n,
    output reg filter_restart,
    output reg cal_start,
    output reg inputs_to_midsupply,
    output reg [7:0] sys_cfg
);
    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers
    wire sclk_s;
    wire cs_n_s;
    wire din_s;
    wire rstp_s;
    acrp_sync u_sclk (.ref_clk(ref_clk), .arst_n(arst_n), .rst_val(1'b0),
        .d(sclk), .q(sclk_s));
    acrp_sync u_cs (.ref_clk(ref_clk), .arst_n(arst_n), .rst_val(1'b1),
        .d(cs_n), .q(cs_n_s));
    acrp_sync u_din (.ref_clk(ref_clk), .arst_n(arst_n), .rst_val(1'b0),
        .d(din), .q(din_s));
    acrp_sync u_rstp (.ref_clk(ref_clk), .arst_n(arst_n), .rst_val(1'b1),
        .d(reset_pin_n), .q(rstp_s));

    // edge detect on the synchronised copies
    reg sclk_d;
    reg cs_d;
    reg rstp_d;
    wire rise = sclk_s & ~sclk_d;
    wire fall = ~sclk_s & sclk_d;
    wire cs_rise = cs_n_s & ~cs_d;
    // reset pin toggle aborts like cs high
    wire rstp_tog = rstp_s ^ rstp_d;
    wire abort = cs_rise | timeout_evt | rstp_tog;
    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            sclk_d <= 1'b0;
            cs_d <= 1'b1;
            rstp_d <= 1'b1; // reset pin idles high, no false toggle
        end else begin
            sclk_d <= sclk_s;
            cs_d <= cs_n_s;
            rstp_d <= rstp_s;
        end
    end

    assign serial_out_oe = ~cs_n_s;

    ////////////////////////////////////////////////////////////////////////
    // register storage
    reg [7:0] regs [0:17];
    integer i;

    ////////////////////////////////////////////////////////////////////////
    // interpreter state
    localparam ST_IDLE = 3'd0;
    localparam ST_RCNT = 3'd1;
    localparam ST_WCNT = 3'd2;
    localparam ST_RDAT = 3'd3;
    localparam ST_WDAT = 3'd4;
    localparam ST_CMDR = 3'd5;
    reg [2:0] state;
    reg [7:0] rx;        // incoming byte shifter
    reg [2:0] rx_cnt;    // bits taken in this byte
    reg [7:0] tx;        // outgoing byte shifter
    reg [2:0] tx_cnt;
    reg [4:0] addr;
    reg [5:0] left;      // bytes remaining in a block
    reg [23:0] holder;   // data-holding copy
    reg [23:0] shifter;  // direct readback copy
    reg [23:0] cmd_copy; // frozen copy for a read by command
    reg [2:0] fidx;      // byte index within frame
    reg [7:0] crc;
    reg first_fall;

    // frame length and byte selector from the option bits
    wire stat_en = sys_cfg[`ACRP_SYS_STAT_BIT];
    wire crc_en = sys_cfg[`ACRP_SYS_CRC_BIT];
    wire [2:0] flen = 3'd3 + {2'b00, stat_en} + {2'b00, crc_en};

    // crc over the three data bytes, msb first
    function [7:0] crc8;
        input [23:0] d;
        integer k;
        reg [7:0] c;
        begin
            c = 8'h00;
            for (k = 23; k >= 0; k = k - 1) begin
                if (c[7] ^ d[k])
                    c = {c[6:0], 1'b0} ^ `ACRP_CRC_POLY;
                else
                    c = {c[6:0], 1'b0};
            end
            crc8 = c;
        end
    endfunction

    // pick a frame byte; status byte carries ready flag in bit 6
    function [7:0] frame_byte;
        input [2:0] idx;
        input [23:0] d;
        input s_en;
        input [7:0] c;
        input rdy_n;
        reg [2:0] j;
        begin
            j = s_en ? idx : idx + 3'd1;
            case (j)
                3'd0: frame_byte = {1'b0, ~rdy_n, 6'h00};
                3'd1: frame_byte = d[23:16];
                3'd2: frame_byte = d[15:8];
                3'd3: frame_byte = d[7:0];
                3'd4: frame_byte = c;
                default: frame_byte = 8'h00;
            endcase
        end
    endfunction

    wire [7:0] rbyte = (addr <= `ACRP_LAST_REG) ? regs[addr] : 8'h00;
    wire [2:0] fnext = (fidx + 3'd1 == flen) ? 3'd0 : fidx + 3'd1;
    wire [7:0] byte_in = {rx[6:0], din_s};
    wire byte_done = rise & (rx_cnt == 3'd7) & ~cs_n_s;

    // first byte of a fresh direct frame, and the next byte of a stream
    wire [7:0] first_byte = frame_byte(3'd0, conv_data, stat_en,
        crc8(conv_data), 1'b0);
    wire [23:0] stream_src = (state == ST_CMDR) ? cmd_copy : shifter;
    wire [7:0] stream_crc = (state == ST_CMDR) ? crc8(cmd_copy) : crc;
    wire [7:0] fbyte = frame_byte(fnext, stream_src, stat_en, stream_crc,
        data_ready_n);

    // write restart test on the watched bits
    function [7:0] watch_mask;
        input [4:0] a;
        begin
            case (a)
                `ACRP_REG_INPMUX, `ACRP_REG_PGA, `ACRP_REG_DATARATE,
                `ACRP_REG_IDACMUX: watch_mask = 8'hff;
                `ACRP_REG_REF: watch_mask = `ACRP_MASK_REF;
                `ACRP_REG_IDACMAG: watch_mask = `ACRP_MASK_IDACMAG;
                `ACRP_REG_SYS: watch_mask = `ACRP_MASK_SYS;
                default: watch_mask = 8'h00;
            endcase
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // main interpreter: rx on rising edges, tx changes on falling edges
    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            state <= ST_IDLE;
            rx <= 8'h00;
            rx_cnt <= 3'd0;
            tx <= 8'h00;
            tx_cnt <= 3'd0;
            addr <= 5'd0;
            left <= 6'd0;
            holder <= 24'h000000;
            shifter <= 24'h000000;
            cmd_copy <= 24'h000000;
            fidx <= 3'd0;
            crc <= 8'h00;
            first_fall <= 1'b0;
            data_ready_n <= 1'b1;
            serial_out_with_ready <= 1'b1;
            filter_restart <= 1'b0;
            cal_start <= 1'b0;
            inputs_to_midsupply <= 1'b0;
            sys_cfg <= 8'h10;
            for (i = 0; i < 18; i = i + 1)
                regs[i] <= 8'h00;
        end else begin
            filter_restart <= 1'b0;
            cal_start <= 1'b0;
            sys_cfg <= regs[`ACRP_REG_SYS];
            // new result: holder always, shifter only if no reg read
            if (conv_done) begin
                holder <= conv_data;
                if (state != ST_RDAT && state != ST_RCNT) begin
                    shifter <= conv_data;
                    crc <= crc8(conv_data);
                    data_ready_n <= 1'b0;
                    first_fall <= 1'b1;
                end
                // restart the direct frame only when no command stream runs
                if (state == ST_IDLE) begin
                    fidx <= 3'd0;
                    tx_cnt <= 3'd0;
                    // msb out now; a leading status byte makes it read low
                    serial_out_with_ready <= first_byte[7];
                    tx <= {first_byte[6:0], 1'b0};
                end
            end
            // calibration finishes into the offset registers
            if (cal_done) begin
                inputs_to_midsupply <= 1'b0;
                regs[`ACRP_REG_OFC0] <= cal_offset[7:0];
                regs[`ACRP_REG_OFC1] <= cal_offset[15:8];
                regs[`ACRP_REG_OFC2] <= cal_offset[23:16];
            end
            if (rise & ~cs_n_s) begin
                rx <= byte_in;
                rx_cnt <= rx_cnt + 3'd1;
            end
            // falling edge: shift out, ready back high on first one
            if (fall & ~cs_n_s) begin
                // a new result in the same cycle keeps ready low
                if (first_fall && !conv_done) begin
                    data_ready_n <= 1'b1;
                    first_fall <= 1'b0;
                end
                serial_out_with_ready <= tx[7];
                tx <= {tx[6:0], 1'b0};
                tx_cnt <= tx_cnt + 3'd1;
                if (tx_cnt == 3'd7) begin
                    // next byte goes out at once so its msb meets the rise
                    if (state == ST_RDAT) begin
                        serial_out_with_ready <= rbyte[7];
                        tx <= {rbyte[6:0], 1'b0};
                    end else begin
                        fidx <= fnext;
                        serial_out_with_ready <= fbyte[7];
                        tx <= {fbyte[6:0], 1'b0};
                    end
                end
            end
            if (abort) begin
                state <= ST_IDLE;
                rx_cnt <= 3'd0;
                tx_cnt <= 3'd0;
            end else if (byte_done) begin
                case (state)
                    ST_IDLE: begin
                        // full duplex decode, also during direct readback
                        if (byte_in[7:1] == `ACRP_OP_RDATA) begin
                            state <= ST_CMDR;
                            // last index, so the closing fall loads byte 0
                            fidx <= flen - 3'd1;
                            cmd_copy <= holder;
                        end else if (byte_in[7:5] == `ACRP_OP_REGISTER_READ_CMD) begin
                            addr <= byte_in[4:0];
                            state <= ST_RCNT;
                        end else if (byte_in[7:5] == `ACRP_OP_REGISTER_WRITE_CMD) begin
                            addr <= byte_in[4:0];
                            state <= ST_WCNT;
                        end else if (byte_in == `ACRP_OP_SELF_OFFSET_CAL_CMD) begin
                            if (converting) begin
                                cal_start <= 1'b1;
                                inputs_to_midsupply <= 1'b1;
                            end
                        end else begin
                            tx <= frame_byte(fnext, shifter, stat_en, crc,
                                data_ready_n);
                        end
                    end
                    ST_RCNT: begin
                        left <= {1'b0, byte_in[4:0]} + 6'd1;
                        state <= ST_RDAT;
                        tx <= rbyte;
                    end
                    ST_WCNT: begin
                        left <= {1'b0, byte_in[4:0]} + 6'd1;
                        state <= ST_WDAT;
                    end
                    ST_RDAT: begin
                        // byte sent; move to next address
                        addr <= addr + 5'd1;
                        left <= left - 6'd1;
                        if (left == 6'd1)
                            state <= ST_IDLE;
                    end
                    ST_WDAT: begin
                        if (addr <= `ACRP_LAST_REG) begin
                            regs[addr] <= byte_in;
                            if (((regs[addr] ^ byte_in) & watch_mask(addr))
                                != 8'h00 && converting) begin
                                filter_restart <= 1'b1;
                                data_ready_n <= 1'b1;
                                shifter <= 24'h000000;
                                holder <= 24'h000000;
                            end
                        end
                        addr <= addr + 5'd1;
                        left <= left - 6'd1;
                        if (left == 6'd1)
                            state <= ST_IDLE;
                    end
                    ST_CMDR: begin
                        // done after a full frame
                        if (fnext == 3'd0)
                            state <= ST_IDLE;
                    end
                    default: state <= ST_IDLE;
                endcase
            end
        end
    end
endmodule
`default_nettype wire

// ### hw/acrp_sync.v
// two flip-flop synchroniser for one level from outside the clock domain
// assumes ref_clk domain and an async active-low reset
`timescale 1ns/1ns
`default_nettype none
module acrp_sync (
    input wire ref_clk,
    input wire arst_n,
    input wire rst_val,
    input wire d,
    output reg q
);
    // stages hold the level relative to rst_val, so both reset to zero
    // and the output still starts at the pin's idle level
    reg meta_x;
    reg q_x;
    // first stage is read only by the second stage
    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            meta_x <= 1'b0;
            q_x <= 1'b0;
        end else begin
            meta_x <= d ^ rst_val;
            q_x <= meta_x;
        end
    end
    // undo the offset on the second stage only
    always @* begin
        q = q_x ^ rst_val;
    end
endmodule
`default_nettype wire

// ### include/acrp_regs.vh
// constants for the adc command and readback port
// assumes a 250 MHz ref_clk; serial pins are sampled, not used as clocks
`ifndef ACRP_REGS_VH
`define ACRP_REGS_VH
// register map
`define ACRP_NUM_REGS 5'd18
`define ACRP_LAST_REG 5'h11
`define ACRP_REG_INPMUX 5'h02
`define ACRP_REG_PGA 5'h03
`define ACRP_REG_DATARATE 5'h04
`define ACRP_REG_REF 5'h05
`define ACRP_REG_IDACMAG 5'h06
`define ACRP_REG_IDACMUX 5'h07
`define ACRP_REG_SYS 5'h09
`define ACRP_REG_OFC0 5'h0a
`define ACRP_REG_OFC1 5'h0b
`define ACRP_REG_OFC2 5'h0c
// restart masks for partially watched registers
`define ACRP_MASK_REF 8'h3f
`define ACRP_MASK_IDACMAG 8'h0f
`define ACRP_MASK_SYS 8'he0
// sys register option bits
`define ACRP_SYS_CRC_BIT 1
`define ACRP_SYS_STAT_BIT 0
// command encodings
`define ACRP_OP_RDATA 7'h09
`define ACRP_OP_SELF_OFFSET_CAL_CMD 8'h19
`define ACRP_OP_REGISTER_READ_CMD 3'h1
`define ACRP_OP_REGISTER_WRITE_CMD 3'h2
// crc polynomial for the optional check byte
`define ACRP_CRC_POLY 8'h07
// device clock periods of quiet before the next ready (figure as printed)
`define ACRP_QUIET_TCLK 28
`endif

// ### test/acrp_host.sv
// host serial master model: sclk idles low and still, 80 ns period
// assumes ref_clk at 4 ns; the bench calls its tasks
`timescale 1ns/1ns
`default_nettype none
module acrp_host (
    input wire logic ref_clk,
    input wire logic sdo,
    output logic sclk,
    output logic cs_n,
    output logic din
);
    // idle: deselected, clock low, data held low
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        din = 1'b0;
    end
    // select level then a quiet gap, so no activity near ready
    task automatic sel(input logic lvl);
        cs_n <= lvl;
        repeat (20) @(posedge ref_clk);
    endtask
    // one byte each way msb first; output is read at the rise
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            din <= tx[i];
            repeat (5) @(posedge ref_clk);
            sclk <= 1'b1;
            rx[i] = sdo;
            repeat (10) @(posedge ref_clk);
            sclk <= 1'b0;
            if (i == 0)
                din <= 1'b0;
            repeat (5) @(posedge ref_clk);
        end
    endtask
endmodule
`default_nettype wire

// ### test/acrp_monitor.sv
// checker for the command and readback port, sees top ports only
// assumes it is bound to acrp_port from the bench top file
`timescale 1ns/1ns
`default_nettype none
module acrp_monitor (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic converting,
    input wire logic conv_done,
    input wire logic serial_out_oe,
    input wire logic data_ready_n,
    input wire logic filter_restart,
    input wire logic cal_start,
    input wire logic inputs_to_midsupply,
    input wire logic [7:0] sys_cfg
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!arst_n);
    // driver follows the synced select, two flops plus margin
    property p_oe_on; (!cs_n)[*4] |-> serial_out_oe; endproperty
    a_oe_on: assert property (p_oe_on) else $error("oe low");
    property p_oe_off; cs_n[*4] |-> !serial_out_oe; endproperty
    a_oe_off: assert property (p_oe_off) else $error("oe high");
    // a result loaded while idle shows up as ready
    property p_rdy_low; conv_done && cs_n |-> ##[1:4] !data_ready_n;
    endproperty
    a_rdy_low: assert property (p_rdy_low) else $error("no ready");
    // first falling serial clock clears ready
    property p_rdy_rel;
        !data_ready_n && !cs_n && $fell(sclk) |-> ##[1:6] data_ready_n;
    endproperty
    a_rdy_rel: assert property (p_rdy_rel) else $error("ready stuck");
    property p_cal_mid; cal_start |-> ##[0:2] inputs_to_midsupply; endproperty
    a_cal_mid: assert property (p_cal_mid) else $error("no short");
    property p_cal_conv; cal_start |-> converting; endproperty
    a_cal_conv: assert property (p_cal_conv) else $error("cal idle");
    property p_rst_conv; filter_restart |-> converting; endproperty
    a_rst_conv: assert property (p_rst_conv) else $error("rst idle");
    property p_rst_rdy; filter_restart |-> ##[0:3] data_ready_n; endproperty
    a_rst_rdy: assert property (p_rst_rdy) else $error("old ready");
    // config leaves its 8'h10 reset value on the first clock, then moves only through a write, which needs the select low
    property p_cfg; cs_n[*8] |=> $stable(sys_cfg); endproperty
    a_cfg: assert property (p_cfg) else $error("cfg moved");
    c_cal: cover property (cal_start);
    c_rst: cover property (filter_restart);
    c_rdy: cover property ($fell(data_ready_n));
endmodule
`default_nettype wire

// ### test/tb_adc_command_readback_port.sv
// bench: host model drives the port, checker bound beside it
// assumes host and checker files compile first
`timescale 1ns/1ns
`default_nettype none
`include "acrp_regs.vh"
module tb_adc_command_readback_port;
    logic ref_clk, arst_n, converting, conv_done, cal_done, rst_pin_n, tmo;
    logic [23:0] conv_data, cal_offset, d;
    wire sclk, cs_n, din, sdo, oe, rdy_n, f_rst, c_st, mid;
    wire [7:0] sys_cfg;
    int bad_count = 0;
    int n_tests = 0;
    int n_rst, n_cal;
    logic [7:0] b, v0, v1;
    logic [7:0] fr [0:7];
    logic [4:0] ra [0:6] = '{5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h07, 5'h09};
    logic [7:0] rv [0:6] = '{8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'he3};
    acrp_host host_u (.ref_clk(ref_clk), .sdo(sdo), .sclk(sclk),
        .cs_n(cs_n), .din(din));
    acrp_port dut_u (.ref_clk(ref_clk), .arst_n(arst_n), .sclk(sclk),
        .cs_n(cs_n), .din(din), .reset_pin_n(rst_pin_n), .timeout_evt(tmo),
        .converting(converting), .conv_done(conv_done),
        .conv_data(conv_data), .cal_done(cal_done), .cal_offset(cal_offset),
        .serial_out_with_ready(sdo), .serial_out_oe(oe),
        .data_ready_n(rdy_n), .filter_restart(f_rst), .cal_start(c_st),
        .inputs_to_midsupply(mid), .sys_cfg(sys_cfg));
    // count one-cycle pulses from the port
    always @(posedge ref_clk) begin
        if (f_rst === 1'b1) n_rst++;
        if (c_st === 1'b1) n_cal++;
    end
    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        n_tests++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic tx(input logic [7:0] t);
        host_u.xfer(t, b);
    endtask
    task automatic rd(input logic [7:0] t, input logic [7:0] exp);
        host_u.xfer(t, b);
        check(b, exp);
    endtask
    task automatic register_write_cmd(input logic [4:0] a, input logic [7:0] x);
        host_u.sel(1'b0);
        tx({3'h2, a});
        tx(8'h00);
        tx(x);
        host_u.sel(1'b1);
    endtask
    task automatic load(input logic [23:0] x);
        conv_data <= x;
        conv_done <= 1'b1;
        @(posedge ref_clk);
        conv_done <= 1'b0;
        repeat (6) @(posedge ref_clk);
    endtask
    // eight bit check byte over the three data bytes, msb first
    function automatic logic [7:0] crc(input logic [23:0] x);
        logic [7:0] c;
        c = 8'h00;
        for (int i = 23; i >= 0; i--)
            c = {c[6:0], 1'b0} ^ ((c[7] ^ x[i]) ? 8'h07 : 8'h00);
        return c;
    endfunction
    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end
    // a hang counts as a mismatch
    initial begin
        repeat (100000) @(posedge ref_clk);
        bad_count++;
        stop_test;
    end
    initial begin
        {arst_n, converting, conv_done, cal_done} = 4'h0;
        {rst_pin_n, tmo} = 2'b10;
        conv_data = 24'h0;
        cal_offset = 24'h0;
        d = $urandom(32'h0cfcb0b1);
        repeat (2) @(posedge ref_clk);
        arst_n <= 1'b1;
        repeat (8) @(posedge ref_clk);
        check(rdy_n, 1'b1);
        check(sys_cfg, 8'h00);
        // block write and read across the end of the map
        {v0, v1} = $urandom;
        converting <= 1'b1;
        n_cal = 0;
        host_u.sel(1'b0);
        tx({3'h2, 5'h10});
        tx(8'h02);
        tx(v0);
        tx(v1);
        tx(8'ha5);
        host_u.sel(1'b0);
        tx({3'h1, 5'h10});
        tx(8'h02);
        rd(`ACRP_OP_SELF_OFFSET_CAL_CMD, v0);
        rd(8'h00, v1);
        rd(8'h00, 8'h00);
        host_u.sel(1'b1);
        check(n_cal, 0);
        $display("test block access done");
        // a timeout, then a reset pin toggle, ends a blocked write
        for (int k = 0; k < 2; k++) begin
            host_u.sel(1'b0);
            tx({3'h2, 5'h10});
            tx(8'h03);
            if (k == 0)
                tmo <= 1'b1;
            else
                rst_pin_n <= 1'b0;
            @(posedge ref_clk);
            tmo <= 1'b0;
            repeat (6) @(posedge ref_clk);
            tx({3'h1, 5'h10});
            tx(8'h00);
            rd(8'h00, v0);
            host_u.sel(1'b1);
            rst_pin_n <= 1'b1;
        end
        $display("test abort done");
        // restart registers: a watched change while converting restarts, a repeat does not
        foreach (ra[i]) begin
            n_rst = 0;
            register_write_cmd(ra[i], rv[i]);
            register_write_cmd(ra[i], rv[i]);
            check(n_rst, 1);
        end
        n_rst = 0;
        register_write_cmd(5'h05, 8'h3f);
        register_write_cmd(5'h06, 8'h0f);
        converting <= 1'b0;
        register_write_cmd(5'h02, 8'h5a);
        check(n_rst, 0);
        check(sys_cfg, 8'he3);
        $display("test restart done");
        // direct readback of a status, data, check frame, then repeat
        d = $urandom;
        load(d);
        check(rdy_n, 1'b0);
        host_u.sel(1'b0);
        for (int i = 0; i < 8; i++) host_u.xfer(8'h00, fr[i]);
        host_u.sel(1'b1);
        check(rdy_n, 1'b1);
        check({fr[1], fr[2], fr[3]}, d);
        check(fr[4], crc(d));
        check({fr[6], fr[7]}, d[23:8]);
        $display("test direct read done");
        // read by command, both opcode forms, new result mid-read
        converting <= 1'b1;
        for (int j = 0; j < 2; j++) begin
            d = $urandom;
            load(d);
            n_cal = 0;
            host_u.sel(1'b0);
            tx({`ACRP_OP_RDATA, j[0]});
            host_u.xfer(`ACRP_OP_SELF_OFFSET_CAL_CMD, fr[0]);
            load(~d);
            for (int i = 1; i < 6; i++) host_u.xfer(8'h00, fr[i]);
            host_u.sel(1'b1);
            check({fr[1], fr[2], fr[3]}, d);
            check(fr[4], crc(d));
            check(n_cal, 0);
        end
        $display("test read command done");
        // self offset cal only while converting, result in offset regs
        for (int c = 0; c <= 1; c++) begin
            converting <= c[0];
            n_cal = 0;
            host_u.sel(1'b0);
            tx(`ACRP_OP_SELF_OFFSET_CAL_CMD);
            host_u.sel(1'b1);
            check(n_cal, c);
            check(mid, c[0]);
        end
        d = $urandom;
        converting <= 1'b1;
        n_cal = 0;
        host_u.sel(1'b0);
        tx(`ACRP_OP_SELF_OFFSET_CAL_CMD);
        host_u.sel(1'b1);
        cal_offset <= d;
        cal_done <= 1'b1;
        @(posedge ref_clk);
        cal_done <= 1'b0;
        repeat (6) @(posedge ref_clk);
        check(mid, 1'b0);
        host_u.sel(1'b0);
        tx({3'h1, 5'h0a});
        tx(8'h02);
        rd(8'h00, d[7:0]);
        rd(8'h00, d[15:8]);
        rd(8'h00, d[23:16]);
        host_u.sel(1'b1);
        $display("test calibration done");
        stop_test;
    end
endmodule
bind acrp_port acrp_monitor mon_u (.ref_clk(ref_clk), .arst_n(arst_n),
    .sclk(sclk), .cs_n(cs_n), .converting(converting),
    .conv_done(conv_done), .serial_out_oe(serial_out_oe),
    .data_ready_n(data_ready_n), .filter_restart(filter_restart),
    .cal_start(cal_start), .inputs_to_midsupply(inputs_to_midsupply),
    .sys_cfg(sys_cfg));
`default_nettype wire
